//--- hdl/sco_pkg.sv
// package: register map, field layout and reset values of the clock control
package sco_pkg;
	localparam logic [7:0] SCO_ADDR_OSC_CONTROL = 8'hb2;
	localparam logic [7:0] SCO_ADDR_OSC_TRIM    = 8'hb3;
	localparam logic [7:0] SCO_ADDR_FLASH_TIME  = 8'hb6;
	localparam logic [7:0] SCO_ADDR_FLASH_CTRL  = 8'hb8;
	localparam logic [7:0] SCO_ADDR_SRC_STATUS  = 8'hbc;
	localparam logic [7:0] SCO_ADDR_PEND        = 8'hc0;
	// osc_control fields, then the flash time and flash control bits
	localparam int SCO_BIT_READY  = 4;
	localparam int SCO_BIT_CLKSEL = 3;
	localparam int SCO_BIT_OSCEN  = 2;
	localparam int SCO_BIT_DIV_HI = 1;
	localparam int SCO_BIT_DIV_LO = 0;
	localparam int SCO_BIT_FPE    = 7;
	localparam int SCO_BIT_FWE    = 0;
	localparam logic [1:0] SCO_DIV8 = 2'h0;
	localparam logic [1:0] SCO_DIV4 = 2'h1;
	localparam logic [1:0] SCO_DIV2 = 2'h2;
	localparam logic [1:0] SCO_DIV1 = 2'h3;
	localparam logic [7:0] SCO_RST_FLASH_TIME = 8'h80;
	localparam logic [6:0] SCO_TRIM_MASK_W    = 7'h7f;
	// oscillator settle time after enable or trim change
	localparam int SCO_SETTLE_NS     = 1000;
	localparam int SCO_CLK_NS        = 25;
	localparam int SCO_SETTLE_CYCLES = SCO_SETTLE_NS / SCO_CLK_NS;
	localparam int SCO_IRQ_W         = 8;
	localparam logic [1:0] SCO_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SCO_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		SCO_SRC_DIV  = 3'h1,
		SCO_SRC_EXT  = 3'h2,
		SCO_SRC_OFF  = 3'h4
	} sco_src_type;
endpackage

//--- hdl/sco_clock_control.sv
// system clock source selection, oscillator trim and flash timing control
//
// The AXI4-Lite slave port is this design's own decision.
module sco_clock_control
	import sco_pkg::*;
#(
	parameter logic [6:0] FACTORY_TRIM = 7'h40
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 ext_osc_valid,
	input  wire logic                 flash_busy,
	input  wire logic [SCO_IRQ_W-1:0] irq_in,
	output logic                      osc_enable,
	output logic [6:0]                osc_trim,
	output logic                      core_clk_en,
	output logic [2:0]                core_src,
	output logic                      flash_pulse_enable,
	output logic                      flash_write_enable,
	output logic [SCO_IRQ_W-1:0]      irq_out
);

	////////////////////////////////////////////////////////////////////////
	// register state
	logic       aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic       w_lane0_r, w_lane0_nxt;
	logic       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic       clksel_r, clksel_nxt, oscen_r, oscen_nxt;
	logic [1:0] div_r, div_nxt;
	logic [6:0] trim_r, trim_nxt;
	logic       trim_loaded_r, trim_loaded_nxt;
	logic       fpe_r, fpe_nxt, fwe_r, fwe_nxt;
	logic [15:0] settle_r, settle_nxt;
	logic       ready_r, ready_nxt;
	logic [2:0] div_cnt_r, div_cnt_nxt;
	logic       en_r, en_nxt;
	logic [SCO_IRQ_W-1:0] pend_r, pend_nxt, irq_r, irq_nxt;
	logic       busy_s1_r, busy_s2_r, ext_s1_r, ext_s2_r;
	logic [SCO_IRQ_W-1:0] irq_s1_r, irq_s2_r;
	logic       do_write, do_read;
	sco_src_type src_r, src_nxt;

	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		unique case (sel)
			SCO_DIV8: div_mask = 3'h7;
			SCO_DIV4: div_mask = 3'h3;
			SCO_DIV2: div_mask = 3'h1;
			SCO_DIV1: div_mask = 3'h0;
		endcase
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		reg_read = 32'h0;
		unique case (a)
			SCO_ADDR_OSC_CONTROL: begin
				reg_read[SCO_BIT_READY]  = ready_r;
				reg_read[SCO_BIT_CLKSEL] = clksel_r;
				reg_read[SCO_BIT_OSCEN]  = oscen_r;
				reg_read[SCO_BIT_DIV_HI:SCO_BIT_DIV_LO] = div_r;
			end
			SCO_ADDR_OSC_TRIM:   reg_read[6:0] = trim_r;
			SCO_ADDR_FLASH_TIME: reg_read[SCO_BIT_FPE] = fpe_r;
			SCO_ADDR_FLASH_CTRL: reg_read[SCO_BIT_FWE] = fwe_r;
			SCO_ADDR_SRC_STATUS: reg_read[2:0] = src_r;
			SCO_ADDR_PEND:       reg_read[SCO_IRQ_W-1:0] = pend_r;
			default:             reg_read = 32'h0;
		endcase
	endfunction

	function automatic logic known(input logic [7:0] a);
		known = (a == SCO_ADDR_OSC_CONTROL) || (a == SCO_ADDR_OSC_TRIM) ||
			(a == SCO_ADDR_FLASH_TIME) || (a == SCO_ADDR_FLASH_CTRL) ||
			(a == SCO_ADDR_SRC_STATUS) || (a == SCO_ADDR_PEND);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready  = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign do_write = aw_have_r && w_have_r && !bvalid_r;
	assign do_read  = s_axi_arvalid && !rvalid_r;

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt  = 1'b1;
			w_data_nxt  = s_axi_wdata;
			w_lane0_nxt = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = known(aw_addr_r) ? SCO_RESP_OKAY : SCO_RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (do_read) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = reg_read(s_axi_araddr);
			rresp_nxt  = known(s_axi_araddr) ? SCO_RESP_OKAY : SCO_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_comb begin
		clksel_nxt      = clksel_r;
		oscen_nxt       = oscen_r;
		div_nxt         = div_r;
		trim_nxt        = trim_r;
		trim_loaded_nxt = 1'b1;
		fpe_nxt         = fpe_r;
		fwe_nxt         = fwe_r;
		// calibration value taken on the first clock after reset release
		if (!trim_loaded_r)
			trim_nxt = FACTORY_TRIM;
		if (do_write && w_lane0_r) begin
			unique case (aw_addr_r)
				SCO_ADDR_OSC_CONTROL: begin
					clksel_nxt = w_data_r[SCO_BIT_CLKSEL];
					oscen_nxt  = w_data_r[SCO_BIT_OSCEN];
					div_nxt    = w_data_r[SCO_BIT_DIV_HI:SCO_BIT_DIV_LO];
				end
				SCO_ADDR_OSC_TRIM:
					trim_nxt = w_data_r[6:0] & SCO_TRIM_MASK_W;
				SCO_ADDR_FLASH_TIME: fpe_nxt = w_data_r[SCO_BIT_FPE];
				SCO_ADDR_FLASH_CTRL: fwe_nxt = w_data_r[SCO_BIT_FWE];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator ready: settles again after enable or trim change
	always_comb begin
		settle_nxt = settle_r;
		ready_nxt  = ready_r;
		if (!oscen_r || trim_nxt != trim_r || !trim_loaded_r) begin
			settle_nxt = 16'(SCO_SETTLE_CYCLES);
			ready_nxt  = 1'b0;
		end else if (settle_r != 16'h0) begin
			settle_nxt = settle_r - 16'h1;
		end else begin
			ready_nxt = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core clock enable: divider pulse or external strobe
	always_comb begin
		div_cnt_nxt = div_cnt_r;
		en_nxt      = 1'b0;
		src_nxt     = src_r;
		if (clksel_r) begin
			src_nxt = SCO_SRC_EXT;
			en_nxt  = ext_s2_r;
		end else if (!oscen_r) begin
			src_nxt = SCO_SRC_OFF;
		end else begin
			src_nxt = SCO_SRC_DIV;
			// wrap counts at or above mask so a new ratio takes effect at once
			if (div_cnt_r >= div_mask(div_r)) begin
				div_cnt_nxt = 3'h0;
				en_nxt      = 1'b1;
			end else begin
				div_cnt_nxt = div_cnt_r + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt hold during flash write or erase
	always_comb begin
		pend_nxt = pend_r | irq_s2_r;
		irq_nxt  = irq_r;
		if (!busy_s2_r && !fwe_r) begin
			irq_nxt  = pend_nxt;
			pend_nxt = '0;
		end else begin
			irq_nxt = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
			ext_s1_r  <= 1'b0;
			ext_s2_r  <= 1'b0;
			irq_s1_r  <= '0;
			irq_s2_r  <= '0;
		end else begin
			busy_s1_r <= flash_busy;
			busy_s2_r <= busy_s1_r;
			ext_s1_r  <= ext_osc_valid;
			ext_s2_r  <= ext_s1_r;
			irq_s1_r  <= irq_in;
			irq_s2_r  <= irq_s1_r;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h0;
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0;
			w_lane0_r <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= SCO_RESP_OKAY;
			rvalid_r  <= 1'b0;
			rresp_r   <= SCO_RESP_OKAY;
			rdata_r   <= 32'h0;
			clksel_r  <= 1'b0;
			oscen_r   <= 1'b1;
			div_r     <= SCO_DIV8;
			trim_r    <= 7'h0;
			trim_loaded_r <= 1'b0;
			fpe_r     <= SCO_RST_FLASH_TIME[SCO_BIT_FPE];
			fwe_r     <= 1'b0;
			settle_r  <= 16'h0;
			ready_r   <= 1'b0;
			div_cnt_r <= 3'h0;
			en_r      <= 1'b0;
			src_r     <= SCO_SRC_DIV;
			pend_r    <= '0;
			irq_r     <= '0;
		end else begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r  <= w_have_nxt;
			w_data_r  <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			clksel_r  <= clksel_nxt;
			oscen_r   <= oscen_nxt;
			div_r     <= div_nxt;
			trim_r    <= trim_nxt;
			trim_loaded_r <= trim_loaded_nxt;
			fpe_r     <= fpe_nxt;
			fwe_r     <= fwe_nxt;
			settle_r  <= settle_nxt;
			ready_r   <= ready_nxt;
			div_cnt_r <= div_cnt_nxt;
			en_r      <= en_nxt;
			src_r     <= src_nxt;
			pend_r    <= pend_nxt;
			irq_r     <= irq_nxt;
		end
	end

	assign osc_enable         = oscen_r;
	assign osc_trim           = trim_r;
	assign core_clk_en        = en_r;
	assign core_src           = src_r;
	assign flash_pulse_enable = fpe_r;
	assign flash_write_enable = fwe_r;
	assign irq_out            = irq_r;

endmodule

//--- tb/sco_clock_control_monitor.sv
// concurrent checks on the clock control ports
module sco_clock_control_monitor
	import sco_pkg::*;
#(
	parameter logic [6:0] FACTORY_TRIM = 7'h40
) (
	input wire logic                 clk,
	input wire logic                 arst_n,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic [1:0]           s_axi_bresp,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic [2:0]           core_src,
	input wire logic                 core_clk_en,
	input wire logic                 osc_enable,
	input wire logic [6:0]           osc_trim,
	input wire logic                 flash_pulse_enable,
	input wire logic                 flash_write_enable,
	input wire logic [SCO_IRQ_W-1:0] irq_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////
	a_src_onehot: assert property ($onehot(core_src))
		else $error("core source not one-hot");
	a_reset_source: assert property ($rose(arst_n) |->
		core_src == SCO_SRC_DIV && osc_enable)
		else $error("reset did not select internal oscillator");
	a_reset_pulse: assert property ($rose(arst_n) |->
		flash_pulse_enable)
		else $error("flash one-shot not set after reset");
	a_trim_factory: assert property ($rose(arst_n) |=>
		osc_trim == FACTORY_TRIM)
		else $error("trim not loaded with factory value");
	a_irq_held: assert property (flash_write_enable |=>
		irq_out == '0)
		else $error("interrupt passed during flash write");
	// core_clk_en is registered in step with core_src, so no pulse trails the switch
	a_off_quiet: assert property (core_src == SCO_SRC_OFF &&
		$past(core_src) == SCO_SRC_OFF &&
		$past(core_src, 2) == SCO_SRC_OFF |-> !core_clk_en)
		else $error("core clock pulse while oscillator off");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
endmodule

bind sco_clock_control sco_clock_control_monitor #(
	.FACTORY_TRIM(FACTORY_TRIM)
) sco_clock_control_monitor_i (
	.clk                (clk),
	.arst_n             (arst_n),
	.s_axi_bvalid       (s_axi_bvalid),
	.s_axi_bready       (s_axi_bready),
	.s_axi_bresp        (s_axi_bresp),
	.s_axi_rvalid       (s_axi_rvalid),
	.s_axi_rready       (s_axi_rready),
	.s_axi_rdata        (s_axi_rdata),
	.core_src           (core_src),
	.core_clk_en        (core_clk_en),
	.osc_enable         (osc_enable),
	.osc_trim           (osc_trim),
	.flash_pulse_enable (flash_pulse_enable),
	.flash_write_enable (flash_write_enable),
	.irq_out            (irq_out)
);

//--- tb/sco_clock_control_tb_top.sv
// self-checking bench for the clock control block
module sco_clock_control_tb_top
	import sco_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] FT = 7'h2a;
	logic        clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, ext_osc_valid;
	logic        flash_busy, osc_enable, core_clk_en, flash_pulse_enable;
	logic        flash_write_enable;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_in, irq_out, v;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [31:0] seed = 32'hc8e38845;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [6:0]  osc_trim;
	logic [2:0]  core_src;
	int          mismatches, checks_done, c, n;

	sco_clock_control #(
		.FACTORY_TRIM(FT)
	) sco_clock_control_i (
		.clk                (clk),
		.arst_n             (arst_n),
		.s_axi_awaddr       (s_axi_awaddr),
		.s_axi_awvalid      (s_axi_awvalid),
		.s_axi_awready      (s_axi_awready),
		.s_axi_wdata        (s_axi_wdata),
		.s_axi_wstrb        (s_axi_wstrb),
		.s_axi_wvalid       (s_axi_wvalid),
		.s_axi_wready       (s_axi_wready),
		.s_axi_bresp        (s_axi_bresp),
		.s_axi_bvalid       (s_axi_bvalid),
		.s_axi_bready       (s_axi_bready),
		.s_axi_araddr       (s_axi_araddr),
		.s_axi_arvalid      (s_axi_arvalid),
		.s_axi_arready      (s_axi_arready),
		.s_axi_rdata        (s_axi_rdata),
		.s_axi_rresp        (s_axi_rresp),
		.s_axi_rvalid       (s_axi_rvalid),
		.s_axi_rready       (s_axi_rready),
		.ext_osc_valid      (ext_osc_valid),
		.flash_busy         (flash_busy),
		.irq_in             (irq_in),
		.osc_enable         (osc_enable),
		.osc_trim           (osc_trim),
		.core_clk_en        (core_clk_en),
		.core_src           (core_src),
		.flash_pulse_enable (flash_pulse_enable),
		.flash_write_enable (flash_write_enable),
		.irq_out            (irq_out)
	);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int div_pulses(input logic [1:0] s, input int w);
		case (s)
			SCO_DIV8: return w / 8;
			SCO_DIV4: return w / 4;
			SCO_DIV2: return w / 2;
			default:  return w;
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// one edge first so back-to-back calls never drive twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, x};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// a late ready now and then makes the response wait for the master
		s_axi_bready <= 1'(rnd());
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		mismatches++;
		conclude();
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'(rnd());
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		mismatches++;
		conclude();
	endtask
	task automatic wrk(input logic [7:0] a, input logic [7:0] x);
		wr(a, x);
		chk(r, SCO_RESP_OKAY);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(r, SCO_RESP_OKAY);
		chk(d, exp);
	endtask
	// ep > 0 also feeds external ticks, then leaves ten quiet cycles
	task automatic cnt(input int w, input int ep);
		c = 0;
		for (int i = 0; i < w; i++) begin
			@(posedge clk);
			if (core_clk_en === 1'b1) c++;
			ext_osc_valid <= ep > 0 && i < w - 10 && i % ep == 0;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
	initial begin
		{arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, ext_osc_valid, flash_busy} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_in} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rchk(SCO_ADDR_OSC_CONTROL, 32'h04);
		rchk(SCO_ADDR_OSC_TRIM, {25'h0, FT});
		rchk(SCO_ADDR_FLASH_TIME, {24'h0, SCO_RST_FLASH_TIME});
		chk(core_src, SCO_SRC_DIV);
		repeat (48) @(posedge clk);
		rchk(SCO_ADDR_OSC_CONTROL, 32'h14);
		for (int s = 0; s < 4; s++) begin
			wrk(SCO_ADDR_OSC_CONTROL, 8'h04 | s[7:0]);
			repeat (8) @(posedge clk);
			cnt(64, 0);
			chk(c, div_pulses(s[1:0], 64));
		end
		v = {1'b0, FT};
		for (int i = 0; i < 3; i++) begin
			d = rnd();
			d[6] = 1'b0;
			// an unchanged trim would not restart the settle time
			if (d[6:0] == v[6:0]) d[0] = ~d[0];
			v = d[7:0];
			wrk(SCO_ADDR_OSC_TRIM, v);
			rchk(SCO_ADDR_OSC_CONTROL, 32'h07);
			rchk(SCO_ADDR_OSC_TRIM, {25'h0, v[6:0]});
			chk(osc_trim, v[6:0]);
		end
		repeat (48) @(posedge clk);
		rchk(SCO_ADDR_OSC_CONTROL, 32'h17);
		wrk(SCO_ADDR_OSC_CONTROL, 8'h00);
		cnt(32, 0);
		chk(c, 0);
		chk({osc_enable, core_src}, {1'b0, SCO_SRC_OFF});
		rchk(SCO_ADDR_OSC_TRIM, {25'h0, v[6:0]});
		wrk(SCO_ADDR_OSC_CONTROL, 8'h0c);
		cnt(70, 3);
		chk(c, 20);
		chk(core_src, SCO_SRC_EXT);
		rchk(SCO_ADDR_SRC_STATUS, {29'h0, SCO_SRC_EXT});
		wrk(SCO_ADDR_OSC_CONTROL, 8'h07);
		wrk(SCO_ADDR_FLASH_TIME, 8'h00);
		chk(flash_pulse_enable, 1'b0);
		rchk(SCO_ADDR_FLASH_TIME, 32'h0);
		wrk(SCO_ADDR_FLASH_TIME, 8'h80);
		v = 8'(rnd()) | 8'h01;
		// hold by write enable first, then by a busy flash
		for (int m = 0; m < 2; m++) begin
			if (m == 0) wrk(SCO_ADDR_FLASH_CTRL, 8'h01);
			else flash_busy <= 1'b1;
			repeat (4) @(posedge clk);
			chk(flash_write_enable, m == 0);
			irq_in <= v;
			repeat (4) @(posedge clk);
			irq_in <= '0;
			repeat (4) @(posedge clk);
			chk(irq_out, 8'h00);
			rchk(SCO_ADDR_PEND, {24'h0, v});
			if (m == 0) wrk(SCO_ADDR_FLASH_CTRL, 8'h00);
			else flash_busy <= 1'b0;
			for (n = 0; n < 20 && irq_out !== v; n++) @(posedge clk);
			chk(irq_out, v);
		end
		// second reset in mid-run, settings away from their defaults
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rchk(SCO_ADDR_OSC_CONTROL, 32'h04);
		chk(core_src, SCO_SRC_DIV);
		rchk(SCO_ADDR_OSC_TRIM, {25'h0, FT});
		// without the low byte lane the register keeps its value
		s_axi_wstrb <= 4'he;
		wrk(SCO_ADDR_OSC_TRIM, 8'h11);
		s_axi_wstrb <= 4'hf;
		rchk(SCO_ADDR_OSC_TRIM, {25'h0, FT});
		wr(8'ha0, 8'h55);
		chk(r, SCO_RESP_SLVERR);
		rd(8'ha0);
		chk(r, SCO_RESP_SLVERR);
		chk(d, 32'h0);
		conclude();
	end
endmodule
